//--- common/pll2_ctrl_regs.vh
// Constants for the second synthesizer loop control block.
// Assumes 8-bit registers reached by sub-address over the two-wire serial port.
`ifndef PLL2_CTRL_REGS_VH
`define PLL2_CTRL_REGS_VH

// Device address on the serial port (arbitrary value)
`define DEV_ADDR          7'h3A

// Per-map register indices, words per map and map bases
`define MAP_NUM_LOW       3'h0
`define MAP_SHARED        3'h1
`define MAP_DEN_LOW       3'h2
`define MAP_INT_DIV       3'h3
`define MAP_CHAN2_DIV     3'h4
`define MAP_CHAN3_DIV     3'h5
`define MAP_WORDS         6
`define MAP0_BASE         3'h0
`define MAP1_BASE         3'h1

// Shared register offsets
`define OFS_GENERAL       8'h08
`define OFS_PAIR_ALIGN    8'h09
`define OFS_SPR_INC       8'h0A
`define OFS_SPR_CNT_LOW   8'h0B
`define OFS_SPR_RATE      8'h0C
`define OFS_FRAC_CTRL     8'h0D
`define OFS_STATUS        8'h0E
`define OFS_OUT_FORMAT    8'h0F

// Field positions and integer divider offset
`define PRESC_MSB         7
`define PRESC_LSB         5
`define POST_MSB          4
`define POST_LSB          0
`define REF_DIV_BIT       1
`define ALIGN_BIT         0
`define SHAPER_PD_BIT     4
`define BLEED_BIT         2
`define CNT_MSB_BIT       7
`define INT_FIELD_MSB     5
`define INT_OFFSET        8'h50

// Reset values
`define RST_NUM_LOW       8'h00
`define RST_SHARED        8'h02
`define RST_DEN_LOW       8'h71
`define RST_INT_DIV       8'h13
`define RST_CHAN_DIV      8'h84
`define RST_GENERAL       8'h00
`define RST_PAIR_ALIGN    8'h00
`define RST_SPR_INC       8'hF9
`define RST_SPR_CNT_LOW   8'h2D
`define RST_SPR_RATE      8'h09
`define RST_FRAC_CTRL     8'h14
`define RST_OUT_FORMAT    8'h00

`endif

//--- rtl/spread_ramp.v
// Triangular ramp of the fractional word offset for spread mode.
// Assumes start is a one-cycle pulse on the same clock, parameters stable after it.
`timescale 1ns/1ps
module spread_ramp (
  // Clock and reset
  input  wire               clk,
  input  wire               rst_n,
  // Control
  input  wire               run,
  input  wire               start,
  input  wire        [8:0]  step_count,
  input  wire signed [7:0]  ramp_increment,
  input  wire        [6:0]  ramp_rate_divider,
  // Offset added to the nominal fractional word, never positive
  output reg  signed [17:0] frac_offset
);

  reg        [6:0]  div_cnt_r;
  reg        [8:0]  step_r;
  reg               rising_r;
  wire       [6:0]  div_last  = (ramp_rate_divider < 7'd2) ? 7'd1 : ramp_rate_divider - 7'd1;
  wire       [8:0]  step_last = (step_count == 9'd0) ? 9'd0 : step_count - 9'd1;
  // Positive increments are forced to zero so the ramp never goes above zero
  wire signed [17:0] inc_ext  = ramp_increment[7] ? {{10{1'b1}}, ramp_increment} : 18'sd0;
  wire               tick     = (div_cnt_r == div_last);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_r   <= 7'h00;
      step_r      <= 9'h000;
      rising_r    <= 1'b0;
      frac_offset <= 18'sd0;
    end else if (!run || start) begin
      div_cnt_r   <= 7'h00;
      step_r      <= 9'h000;
      rising_r    <= 1'b0;
      frac_offset <= 18'sd0;
    end else begin
      div_cnt_r <= tick ? 7'h00 : div_cnt_r + 7'd1;
      if (tick) begin
        if (rising_r)
          frac_offset <= frac_offset - inc_ext;
        else
          frac_offset <= frac_offset + inc_ext;
        if (step_r == step_last) begin
          step_r   <= 9'h000;
          rising_r <= ~rising_r;
        end else begin
          step_r <= step_r + 9'd1;
        end
      end
    end
  end

endmodule // spread_ramp

//--- rtl/pll2_freq_map_spread_ctrl.v
// Second synthesizer loop digital control: serial register port, two maps, spread.
// Assumes scl/sda and both control pins are asynchronous to ref_clk.
`timescale 1ns/1ps
`include "pll2_ctrl_regs.vh"
module pll2_freq_map_spread_ctrl (
  // Clock and reset
  input  wire               ref_clk,
  input  wire               resetn,
  // Serial control port, open drain data
  input  wire               scl,
  input  wire               sda_in,
  output reg                sda_out,
  output reg                sda_oe_n,
  // Board control pins
  input  wire               alt_map_select_pin,
  input  wire               spread_select_pin,
  // Feedback loop controls
  output reg         [7:0]  loop2_integer_divider,
  output reg  signed [17:0] noise_shaper_frac,
  output reg         [11:0] fine_denominator,
  output reg                noise_shaper_pd,
  output reg                bleed_en,
  output reg                ref_predivide_by_two,
  output reg                new_acq,
  output reg                spread_active,
  // Output channel controls
  output reg         [2:0]  chan_b_prescaler,
  output reg         [4:0]  chan_b_post_divider,
  output reg         [2:0]  chan_c_prescaler,
  output reg         [4:0]  chan_c_post_divider,
  output reg                pair_edge_align,
  output reg         [1:0]  buffer_format
);

  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_ADDR = 9'h002;
  localparam [8:0] S_ACKA = 9'h004;
  localparam [8:0] S_SUB  = 9'h008;
  localparam [8:0] S_ACKS = 9'h010;
  localparam [8:0] S_WDAT = 9'h020;
  localparam [8:0] S_ACKW = 9'h040;
  localparam [8:0] S_RDAT = 9'h080;
  localparam [8:0] S_ACKR = 9'h100;
  // Reset release and pin synchronisers
  reg        rst_s1_r, rst_n;
  reg  [3:0] pin_s1_r, pin_s2_r;
  reg        scl_d_r, sda_d_r, alt_d_r, spr_d_r;
  wire       scl_s = pin_s2_r[0];
  wire       sda_s = pin_s2_r[1];
  wire       alt_s = pin_s2_r[2];
  wire       spr_s = pin_s2_r[3];

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 4'h3;
      pin_s2_r <= 4'h3;
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
      alt_d_r  <= 1'b0;
      spr_d_r  <= 1'b0;
    end else begin
      pin_s1_r <= {spread_select_pin, alt_map_select_pin, sda_in, scl};
      pin_s2_r <= pin_s1_r;
      scl_d_r  <= scl_s;
      sda_d_r  <= sda_s;
      alt_d_r  <= alt_s;
      spr_d_r  <= spr_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;
  // Register storage
  reg [7:0] map0_r [0:`MAP_WORDS-1];
  reg [7:0] map1_r [0:`MAP_WORDS-1];
  reg [7:0] general_r, align_r, spr_inc_r, spr_cnt_r, spr_rate_r, frac_ctrl_r, format_r;

  function [7:0] map_default;
    input [2:0] idx;
    begin
      case (idx)
        `MAP_NUM_LOW:   map_default = `RST_NUM_LOW;
        `MAP_SHARED:    map_default = `RST_SHARED;
        `MAP_DEN_LOW:   map_default = `RST_DEN_LOW;
        `MAP_INT_DIV:   map_default = `RST_INT_DIV;
        default:        map_default = `RST_CHAN_DIV;
      endcase
    end
  endfunction
  // Map registers sit at base*32 + index
  function map_hit;
    input [7:0] addr;
    input [2:0] base;
    begin
      map_hit = (addr[7:5] == base) && (addr[4:0] < `MAP_WORDS);
    end
  endfunction

  function [7:0] reg_read;
    input [7:0] addr;
    begin
      if (map_hit(addr, `MAP0_BASE))
        reg_read = map0_r[addr[2:0]];
      else if (map_hit(addr, `MAP1_BASE))
        reg_read = map1_r[addr[2:0]];
      else begin
        case (addr)
          `OFS_GENERAL:    reg_read = general_r;
          `OFS_PAIR_ALIGN: reg_read = align_r;
          `OFS_SPR_INC:    reg_read = spr_inc_r;
          `OFS_SPR_CNT_LOW: reg_read = spr_cnt_r;
          `OFS_SPR_RATE:   reg_read = spr_rate_r;
          `OFS_FRAC_CTRL:  reg_read = frac_ctrl_r;
          `OFS_STATUS:     reg_read = {5'h00, pair_edge_align, spread_active, alt_d_r};
          `OFS_OUT_FORMAT: reg_read = format_r;
          default:         reg_read = 8'h00;
        endcase
      end
    end
  endfunction
  // Serial slave
  reg [8:0] state_r;
  reg [3:0] cnt_r;
  reg [7:0] rx_r, tx_r, sub_r;
  reg       rw_r, wr_stb_r;
  reg [7:0] wr_addr_r, wr_data_r;
  wire [7:0] rd_byte = reg_read(sub_r);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= S_IDLE;
      cnt_r     <= 4'h0;
      rx_r      <= 8'h00;
      tx_r      <= 8'h00;
      sub_r     <= 8'h00;
      rw_r      <= 1'b0;
      wr_stb_r  <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
      sda_out   <= 1'b0;
      sda_oe_n  <= 1'b1;
    end else begin
      wr_stb_r <= 1'b0;
      if (scl_rise)
        rx_r <= {rx_r[6:0], sda_s};
      if (start_c) begin
        state_r  <= S_ADDR;
        cnt_r    <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_c) begin
        state_r  <= S_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        case (state_r)
          S_IDLE: state_r <= S_IDLE;
          S_ADDR, S_SUB, S_WDAT: begin
            if (scl_rise)
              cnt_r <= cnt_r + 4'd1;
            if (scl_fall && cnt_r == 4'd8) begin
              cnt_r    <= 4'h0;
              sda_oe_n <= 1'b0;
              if (state_r == S_ADDR) begin
                rw_r <= rx_r[0];
                if (rx_r[7:1] == `DEV_ADDR)
                  state_r <= S_ACKA;
                else begin
                  state_r  <= S_IDLE;
                  sda_oe_n <= 1'b1;
                end
              end else if (state_r == S_SUB) begin
                sub_r   <= rx_r;
                state_r <= S_ACKS;
              end else begin
                wr_stb_r  <= 1'b1;
                wr_addr_r <= sub_r;
                wr_data_r <= rx_r;
                sub_r     <= sub_r + 8'd1;
                state_r   <= S_ACKW;
              end
            end
          end
          S_ACKA, S_ACKS, S_ACKW, S_ACKR: begin
            // A master that does not acknowledge ends the read
            if (state_r == S_ACKR && scl_rise && sda_s)
              state_r <= S_IDLE;
            else if (scl_fall) begin
              if ((state_r == S_ACKA && rw_r) || state_r == S_ACKR) begin
                tx_r     <= {rd_byte[6:0], 1'b0};
                sda_oe_n <= rd_byte[7];
                sub_r    <= sub_r + 8'd1;
                state_r  <= S_RDAT;
              end else begin
                sda_oe_n <= 1'b1;
                state_r  <= (state_r == S_ACKA) ? S_SUB : S_WDAT;
              end
            end
          end
          S_RDAT: begin
            if (scl_rise)
              cnt_r <= cnt_r + 4'd1;
            if (scl_fall) begin
              if (cnt_r == 4'd8) begin
                cnt_r    <= 4'h0;
                sda_oe_n <= 1'b1;
                state_r  <= S_ACKR;
              end else begin
                sda_oe_n <= tx_r[7];
                tx_r     <= {tx_r[6:0], 1'b0};
              end
            end
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end

  // Register writes
  integer i;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `MAP_WORDS; i = i + 1) begin
        map0_r[i] <= map_default(i[2:0]);
        map1_r[i] <= map_default(i[2:0]);
      end
      general_r   <= `RST_GENERAL;
      align_r     <= `RST_PAIR_ALIGN;
      spr_inc_r   <= `RST_SPR_INC;
      spr_cnt_r   <= `RST_SPR_CNT_LOW;
      spr_rate_r  <= `RST_SPR_RATE;
      frac_ctrl_r <= `RST_FRAC_CTRL;
      format_r    <= `RST_OUT_FORMAT;
    end else if (wr_stb_r) begin
      if (map_hit(wr_addr_r, `MAP0_BASE))
        map0_r[wr_addr_r[2:0]] <= wr_data_r;
      else if (map_hit(wr_addr_r, `MAP1_BASE))
        map1_r[wr_addr_r[2:0]] <= wr_data_r;
      else begin
        case (wr_addr_r)
          `OFS_GENERAL:     general_r   <= wr_data_r;
          `OFS_PAIR_ALIGN:  align_r     <= wr_data_r;
          `OFS_SPR_INC:     spr_inc_r   <= wr_data_r;
          `OFS_SPR_CNT_LOW: spr_cnt_r   <= wr_data_r;
          `OFS_SPR_RATE:    spr_rate_r  <= wr_data_r;
          `OFS_FRAC_CTRL:   frac_ctrl_r <= wr_data_r;
          `OFS_OUT_FORMAT:  format_r    <= wr_data_r;
          default:          format_r    <= format_r;
        endcase
      end
    end
  end
  // Active map selection
  wire [7:0] num_lo  = alt_d_r ? map1_r[`MAP_NUM_LOW]   : map0_r[`MAP_NUM_LOW];
  wire [7:0] shared  = alt_d_r ? map1_r[`MAP_SHARED]    : map0_r[`MAP_SHARED];
  wire [7:0] den_lo  = alt_d_r ? map1_r[`MAP_DEN_LOW]   : map0_r[`MAP_DEN_LOW];
  wire [7:0] int_div = alt_d_r ? map1_r[`MAP_INT_DIV]   : map0_r[`MAP_INT_DIV];
  wire [7:0] ch2_div = alt_d_r ? map1_r[`MAP_CHAN2_DIV] : map0_r[`MAP_CHAN2_DIV];
  wire [7:0] ch3_div = alt_d_r ? map1_r[`MAP_CHAN3_DIV] : map0_r[`MAP_CHAN3_DIV];
  wire [11:0] numerator = {num_lo, shared[7:4]};
  // Spread parameters are captured only at the pin's rising edge
  reg  [8:0] cnt_lat_r;
  reg  [7:0] inc_lat_r;
  reg  [6:0] rate_lat_r;
  wire       spr_start = spr_s & ~spr_d_r;
  wire signed [17:0] frac_offset;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_lat_r  <= 9'h000;
      inc_lat_r  <= 8'h00;
      rate_lat_r <= 7'h00;
    end else if (spr_start) begin
      cnt_lat_r  <= {spr_rate_r[`CNT_MSB_BIT], spr_cnt_r};
      inc_lat_r  <= spr_inc_r;
      rate_lat_r <= spr_rate_r[6:0];
    end
  end

  spread_ramp ramp_u (
    .clk               (ref_clk),
    .rst_n             (rst_n),
    .run               (spr_d_r),
    .start             (spr_start),
    .step_count        (cnt_lat_r),
    .ramp_increment    (inc_lat_r),
    .ramp_rate_divider (rate_lat_r),
    .frac_offset       (frac_offset)
  );
  // Registered outputs
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      loop2_integer_divider <= `INT_OFFSET;
      noise_shaper_frac     <= 18'sd0;
      fine_denominator      <= 12'h000;
      noise_shaper_pd       <= 1'b1;
      bleed_en              <= 1'b0;
      ref_predivide_by_two  <= 1'b0;
      new_acq               <= 1'b0;
      spread_active         <= 1'b0;
      chan_b_prescaler      <= 3'h0;
      chan_b_post_divider   <= 5'h00;
      chan_c_prescaler      <= 3'h0;
      chan_c_post_divider   <= 5'h00;
      pair_edge_align       <= 1'b0;
      buffer_format         <= 2'h0;
    end else begin
      loop2_integer_divider <= {2'b00, int_div[`INT_FIELD_MSB:0]} + `INT_OFFSET;
      noise_shaper_frac     <= $signed({6'h00, numerator}) + frac_offset;
      fine_denominator      <= {shared[3:0], den_lo};
      noise_shaper_pd       <= frac_ctrl_r[`SHAPER_PD_BIT];
      bleed_en              <= frac_ctrl_r[`BLEED_BIT];
      ref_predivide_by_two  <= general_r[`REF_DIV_BIT];
      new_acq               <= alt_s ^ alt_d_r;
      spread_active         <= spr_d_r;
      chan_b_prescaler      <= ch2_div[`PRESC_MSB:`PRESC_LSB];
      chan_b_post_divider   <= ch2_div[`POST_MSB:`POST_LSB];
      chan_c_prescaler      <= ch3_div[`PRESC_MSB:`PRESC_LSB];
      chan_c_post_divider   <= ch3_div[`POST_MSB:`POST_LSB];
      pair_edge_align       <= align_r[`ALIGN_BIT] && (ch2_div[`PRESC_MSB:`PRESC_LSB] ==
                               ch3_div[`PRESC_MSB:`PRESC_LSB]);
      buffer_format         <= format_r[1:0];
    end
  end

endmodule // pll2_freq_map_spread_ctrl

//--- dv/pll2_freq_map_spread_ctrl_properties.sv
// Checker for the second loop control block, bound to its top module.
// Assumes every pin is driven just after a rising ref_clk edge.
`timescale 1ns/1ps
module pll2_ctrl_props (
  // Clock and reset
  input wire logic               ref_clk,
  input wire logic               resetn,
  // Board pins
  input wire logic               alt_map_select_pin,
  input wire logic               spread_select_pin,
  // Observed outputs
  input wire logic        [7:0]  loop2_integer_divider,
  input wire logic signed [17:0] noise_shaper_frac,
  input wire logic               noise_shaper_pd,
  input wire logic               bleed_en,
  input wire logic               new_acq,
  input wire logic               spread_active,
  input wire logic        [2:0]  chan_b_prescaler,
  input wire logic        [2:0]  chan_c_prescaler,
  input wire logic               pair_edge_align,
  input wire logic        [1:0]  buffer_format
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Nominal word, taken only once the ramp offset has surely settled to zero
  logic        [1:0]  idle_cnt_r;
  logic signed [17:0] nom_r;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      idle_cnt_r <= 2'd0;
      nom_r      <= 18'sd0;
    end else if (spread_active) begin
      idle_cnt_r <= 2'd0;
    end else if (idle_cnt_r != 2'd3) begin
      idle_cnt_r <= idle_cnt_r + 2'd1;
    end else begin
      nom_r      <= noise_shaper_frac;
    end
  end
  a_acq_on_change: assert property ($changed(alt_map_select_pin) |-> ##[1:4] new_acq)
    else $error("no acquisition pulse after map pin change");
  a_acq_one_cycle: assert property (new_acq |=> !new_acq)
    else $error("acquisition pulse longer than one cycle");
  a_int_offset: assert property (loop2_integer_divider >= 8'h50)
    else $error("integer divider below offset");
  a_shared_ctrl: assert property ($changed(alt_map_select_pin) |->
      ##1 $stable({buffer_format, noise_shaper_pd, bleed_en})[*6])
    else $error("shared setting moved on map switch");
  a_align_equal: assert property (pair_edge_align && $stable({chan_b_prescaler,
      chan_c_prescaler}) |-> chan_b_prescaler == chan_c_prescaler)
    else $error("edge align with unequal prescalers");
  a_spread_on: assert property ($rose(spread_select_pin) |-> ##[1:4] spread_active)
    else $error("spread not entered");
  a_spread_off: assert property ($fell(spread_select_pin) |-> ##[1:4] !spread_active)
    else $error("spread not left");
  a_down_only: assert property (spread_active |-> noise_shaper_frac <= nom_r &&
      noise_shaper_frac >= nom_r - 18'sd65408)
    else $error("fractional word outside downspread span");
  a_step_rate: assert property (spread_select_pin[*5] ##0 $changed(noise_shaper_frac)
      |=> $stable(noise_shaper_frac))
    else $error("ramp stepped on consecutive cycles");
endmodule // pll2_ctrl_props

bind pll2_freq_map_spread_ctrl pll2_ctrl_props pll2_ctrl_props_i (
  .ref_clk(ref_clk), .resetn(resetn), .alt_map_select_pin(alt_map_select_pin),
  .spread_select_pin(spread_select_pin), .loop2_integer_divider(loop2_integer_divider),
  .noise_shaper_frac(noise_shaper_frac), .noise_shaper_pd(noise_shaper_pd),
  .bleed_en(bleed_en), .new_acq(new_acq), .spread_active(spread_active),
  .chan_b_prescaler(chan_b_prescaler), .chan_c_prescaler(chan_c_prescaler),
  .pair_edge_align(pair_edge_align), .buffer_format(buffer_format));

//--- dv/i2c_host_model.sv
// Two-wire serial host: drives the clock and an open-drain data release.
// Assumes the bench resolves the pulled-up data wire and feeds it back.
`timescale 1ns/1ps
module i2c_host_model (
  // Clock
  input  wire logic clk,
  // Serial bus
  input  wire logic sda,
  output logic      scl,
  output logic      sda_rel
);
  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves mid low phase, so the device never sees a false start
  task automatic bit_io(input logic b, output logic r);
    wt(4);
    sda_rel <= b;
    wt(8);
    scl <= 1'b1;
    wt(8);
    r = sda;
    scl <= 1'b0;
  endtask
  // s=1 start or repeated start, s=0 stop
  task automatic cond(input logic s);
    wt(4);
    sda_rel <= s;
    wt(8);
    scl <= 1'b1;
    wt(8);
    sda_rel <= !s;
    wt(8);
    if (s) scl <= 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'b1, ack);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] sub, input logic [7:0] d,
                    output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    cond(1'b1);
    xbyte({dev, 1'b0}, q, a0);
    xbyte(sub, q, a1);
    xbyte(d, q, a2);
    cond(1'b0);
    ok = !(a0 | a1 | a2);
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] sub, output logic [7:0] d,
                    output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, nk;
    cond(1'b1);
    xbyte({dev, 1'b0}, q, a0);
    xbyte(sub, q, a1);
    cond(1'b1);
    xbyte({dev, 1'b1}, q, a2);
    xbyte(8'hFF, d, nk);
    cond(1'b0);
    ok = !(a0 | a1 | a2);
  endtask
endmodule // i2c_host_model

//--- dv/pll2_freq_map_spread_ctrl_tb.sv
// Self-checking bench for the second loop control block.
// Assumes the register header is on the include path.
`timescale 1ns/1ps
`include "pll2_ctrl_regs.vh"
module pll2_freq_map_spread_ctrl_tb;
  logic               ref_clk, resetn, alt_pin, spr_pin;
  wire                scl, sda_rel, sda, sda_out, sda_oe_n, pd, bleed, pre2, new_acq;
  wire                spr_act, align;
  wire        [7:0]   loop2;
  wire signed [17:0]  frac;
  wire        [11:0]  den;
  wire        [2:0]   bp, cp;
  wire        [4:0]   bd, cd;
  wire        [1:0]   fmt;
  int                 failures = 0;
  int                 comparisons = 0;
  logic       [7:0]   dflt [6] = '{8'h00, 8'h02, 8'h71, 8'h13, 8'h84, 8'h84};
  logic       [7:0]   m0 [6] = '{8'h14, 8'hD2, 8'h71, 8'h13, 8'h84, 8'h90};
  logic       [7:0]   m1 [6] = '{8'h0C, 8'h62, 8'h71, 8'hFF, 8'h48, 8'h68};
  // Pulled-up open-drain data wire
  assign sda = sda_rel & sda_oe_n;
  i2c_host_model i2c_host_model_i (.clk(ref_clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));
  pll2_freq_map_spread_ctrl pll2_freq_map_spread_ctrl_i (
    .ref_clk(ref_clk), .resetn(resetn), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .alt_map_select_pin(alt_pin), .spread_select_pin(spr_pin),
    .loop2_integer_divider(loop2), .noise_shaper_frac(frac), .fine_denominator(den),
    .noise_shaper_pd(pd), .bleed_en(bleed), .ref_predivide_by_two(pre2),
    .new_acq(new_acq), .spread_active(spr_act), .chan_b_prescaler(bp),
    .chan_b_post_divider(bd), .chan_c_prescaler(cp), .chan_c_post_divider(cd),
    .pair_edge_align(align), .buffer_format(fmt));
  task automatic end_of_test();
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] sub, input logic [7:0] d);
    logic ok;
    i2c_host_model_i.wr(`DEV_ADDR, sub, d, ok);
    chk("write ack", 1, ok);
  endtask
  task automatic rdchk(input logic [7:0] sub, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    i2c_host_model_i.rd(`DEV_ADDR, sub, d, ok);
    chk("read ack", 1, ok);
    chk("read data", e, d);
  endtask
  task automatic chk_map(input logic [7:0] w [6], input logic al);
    chk("integer", 18'd80 + 18'(w[3][5:0]), loop2);
    chk("fraction", {w[0], w[1][7:4]}, frac);
    chk("denominator", {w[1][3:0], w[2]}, den);
    chk("b prescaler", w[4][7:5], bp);
    chk("b post", w[4][4:0], bd);
    chk("c prescaler", w[5][7:5], cp);
    chk("c post", w[5][4:0], cd);
    chk("edge align", al & (w[4][7:5] == w[5][7:5]), align);
  endtask
  task automatic pin_acq(input logic v);
    int n;
    @(posedge ref_clk);
    alt_pin <= v;
    n = 0;
    repeat (10) begin
      @(negedge ref_clk);
      n += new_acq;
    end
    chk("acq pulses", 1, 18'(n));
  endtask
  task automatic nxt(output int gap);
    logic [17:0] p;
    p = frac;
    gap = 0;
    do begin
      @(negedge ref_clk);
      gap++;
    end while (frac === p && gap < 300);
  endtask
  // Triangle: inc is negative, down cnt steps first, one step per dv cycles
  task automatic ramp(input int nom, input int inc, input int cnt, input int dv, input int n);
    int v, g;
    v = nom;
    for (int k = 0; k < n; k++) begin
      v = v + (((k / cnt) % 2) ? -inc : inc);
      nxt(g);
      chk("ramp value", 18'(v), frac);
      if (k > 0) chk("ramp gap", 18'(dv), 18'(g));
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (80000) @(posedge ref_clk);
    failures++;
    end_of_test();
  end
  initial begin
    logic ok;
    logic [17:0] a;
    int g;
    resetn = 1'b0;
    alt_pin = 1'b0;
    spr_pin = 1'b0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (8) @(negedge ref_clk);
    chk_map(dflt, 1'b0);
    chk("shaper pd", 1, pd);
    chk("data out", 0, sda_out);
    i2c_host_model_i.wr(7'h3B, 8'h03, 8'h3F, ok);
    chk("foreign ack", 0, ok);
    rdchk(8'h03, 8'h13);
    rdchk(8'h30, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wreg(8'(i), m0[i]);
      wreg(8'(8'h20 + i), m1[i]);
    end
    wreg(8'h09, 8'h01);
    wreg(8'h0F, 8'h02);
    wreg(8'h0D, 8'h04);
    wreg(8'h08, 8'h02);
    chk("predivide", 1, pre2);
    wreg(8'h08, 8'h00);
    chk("predivide", 0, pre2);
    chk_map(m0, 1'b1);
    pin_acq(1'b1);
    chk_map(m1, 1'b1);
    chk("format", 2, fmt);
    chk("shaper pd", 0, pd);
    chk("bleed", 1, bleed);
    rdchk(8'h0E, 8'h01);
    pin_acq(1'b0);
    chk_map(m0, 1'b1);
    wreg(8'h0A, 8'hFD);
    wreg(8'h0B, 8'h04);
    wreg(8'h0C, 8'h03);
    @(posedge ref_clk);
    spr_pin <= 1'b1;
    ramp(333, -3, 4, 3, 12);
    wreg(8'h0A, 8'hFE);
    nxt(g);
    a = frac;
    nxt(g);
    chk("held step", 3, (a > frac) ? a - frac : frac - a);
    chk("spread on", 1, spr_act);
    @(posedge ref_clk);
    spr_pin <= 1'b0;
    repeat (8) @(negedge ref_clk);
    chk("nominal", 333, frac);
    chk("spread off", 0, spr_act);
    @(posedge ref_clk);
    spr_pin <= 1'b1;
    ramp(333, -2, 4, 3, 9);
    @(posedge ref_clk);
    spr_pin <= 1'b0;
    repeat (8) @(negedge ref_clk);
    end_of_test();
  end
endmodule // pll2_freq_map_spread_ctrl_tb
